// *** rtl/local_bus_master.sv ***
// Notes on behaviour
// - Bus clock is input clock halved.
// - Address state: word address, length in bits 1:0.
// - Data state carries full 32-bit data word.
// - Data lines float unless driving address or writes.
// - Length code 00..11 means one to four words.
// - Latch strobe low in address state, high before data.
// - Latch strobe active low, floats in hold.
// - Status strobe low in address, high next data.
// - Burst: status strobe again after each ready but the last.
// - Write/read shown at address, held through data.
// - Direction low for reads and acknowledges, high writes.
// - Direction never changes while data enable asserted.
// - No ready in data state inserts a wait state.
// - No status strobe after a data state without ready.
// - Lock keeps other masters off during read-modify-write.
// - Lock is open drain, driven and sensed.
// - Wait for foreign lock; lock at read, release at write.
// - Lock also held during interrupt acknowledges.
// - Hold grant floats bus lines and raises grant.
module local_bus_master (
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RESETN,
  // Transaction requests.
  input wire logic REQ_VALID,
  output logic REQ_ACK,
  input wire logic REQ_WRITE,
  input wire logic REQ_LOCKED,
  input wire logic REQ_INTACK,
  input wire logic [29:0] REQ_WORD_ADDR,
  input wire logic [1:0] REQ_LEN,
  // Write data.
  input wire logic WDATA_VALID,
  output logic WDATA_READY,
  input wire logic [31:0] WDATA,
  // Read data.
  output logic RDATA_VALID,
  output logic [31:0] RDATA,
  // Bus pins.
  output logic PROC_CLK,
  input wire logic [31:0] MUXED_ADDR_DATA_I,
  output logic [31:0] MUXED_ADDR_DATA_O,
  output logic MUXED_ADDR_DATA_OE,
  output logic ADDR_LATCH_STROBE_N,
  output logic ADDR_LATCH_STROBE_OE,
  output logic ADDR_DATA_STATUS_N,
  output logic WRITE_NOT_READ,
  output logic TRANSCEIVER_DIRECTION,
  output logic DATA_ENABLE_N,
  output logic CTRL_OE,
  input wire logic READY_N,
  // Lock line and hold handshake.
  input wire logic BUS_LOCK_N_I,
  output logic BUS_LOCK_N_O,
  output logic BUS_LOCK_N_OE,
  input wire logic HOLD_REQ,
  output logic HOLD_GRANT
);

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_WAIT, ST_HOLD} bus_state_t;

  logic [lbus_pkg::SYNC_W-1:0] sync_out;
  logic hold_s, ready_s, lock_s;
  logic [31:0] lad_s;
  logic [31:0] wf_data, wf_next;
  logic wf_valid, wf_pop;
  logic [2:0] wf_level;

  pin_sync #(.W(lbus_pkg::SYNC_W)) u_sync (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .pin_in({HOLD_REQ, READY_N, BUS_LOCK_N_I, MUXED_ADDR_DATA_I}),
    .pin_out(sync_out)
  );

  assign hold_s = sync_out[lbus_pkg::WORD_W + 2];
  assign ready_s = !sync_out[lbus_pkg::WORD_W + 1];
  assign lock_s = !sync_out[lbus_pkg::WORD_W];
  assign lad_s = sync_out[lbus_pkg::WORD_W-1:0];

  word_fifo #(.WIDTH(lbus_pkg::WORD_W), .DEPTH(lbus_pkg::WFIFO_DEPTH)) u_wfifo (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .in_valid(WDATA_VALID),
    .in_ready(WDATA_READY),
    .in_data(WDATA),
    .out_valid(wf_valid),
    .out_ready(wf_pop),
    .out_data(wf_data),
    .out_next(wf_next),
    .level(wf_level)
  );

  // Bus sequencer state.
  bus_state_t state_q, state_d;
  logic phase_q, phase_d;
  logic [1:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  logic intack_q, intack_d;
  logic lock_q, lock_d;
  logic [29:0] addr_q, addr_d;
  logic [1:0] len_q, len_d;
  logic take, lock_busy, can_start, done, beat;

  assign lock_busy = lock_s && !lock_q;
  assign can_start = REQ_VALID && (!REQ_WRITE || (wf_level > {1'b0, REQ_LEN}))
                     && !((REQ_LOCKED || REQ_INTACK) && lock_busy);
  assign beat = phase_q && ready_s && (state_q == ST_DATA || state_q == ST_WAIT);
  assign done = beat && (cnt_q == 2'h0);
  assign wf_pop = beat && wr_q && wf_valid;

  always_comb begin
    phase_d = !phase_q;
    state_d = state_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    intack_d = intack_q;
    lock_d = lock_q;
    addr_d = addr_q;
    len_d = len_q;
    take = 1'b0;
    if (phase_q) begin
      case (state_q)
        ST_IDLE: begin
          if (hold_s && !lock_q) begin
            state_d = ST_HOLD;
          end else if (can_start) begin
            take = 1'b1;
          end
        end
        ST_ADDR: begin
          state_d = ST_DATA;
        end
        ST_DATA, ST_WAIT: begin
          if (!ready_s) begin
            state_d = ST_WAIT;
          end else if (cnt_q != 2'h0) begin
            cnt_d = cnt_q - 2'h1;
            state_d = ST_DATA;
          end else begin
            state_d = ST_IDLE;
            if (intack_q) begin
              lock_d = 1'b0;
            end
            if (!(hold_s && !lock_d) && can_start) begin
              take = 1'b1;
            end
          end
        end
        ST_HOLD: begin
          if (!hold_s) begin
            state_d = ST_IDLE;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
    if (take) begin
      state_d = ST_ADDR;
      wr_d = REQ_WRITE;
      intack_d = REQ_INTACK;
      addr_d = REQ_WORD_ADDR;
      len_d = REQ_LEN;
      cnt_d = REQ_LEN;
      if (REQ_WRITE) begin
        lock_d = 1'b0;
      end else if (REQ_LOCKED || REQ_INTACK) begin
        lock_d = 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= ST_IDLE;
      phase_q <= 1'b0;
      cnt_q <= 2'h0;
      wr_q <= 1'b0;
      intack_q <= 1'b0;
      lock_q <= 1'b0;
      addr_q <= 30'h0000_0000;
      len_q <= lbus_pkg::LEN_ONE;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      intack_q <= intack_d;
      lock_q <= lock_d;
      addr_q <= addr_d;
      len_q <= len_d;
    end
  end

  // Registered pin outputs.
  logic [31:0] lad_o_q, lad_o_d, rdata_q, rdata_d;
  logic lad_oe_q, lad_oe_d, ale_n_q, ale_n_d, ale_oe_q, ale_oe_d;
  logic ads_n_q, ads_n_d, wnr_q, wnr_d, dir_q, dir_d, den_n_q, den_n_d;
  logic ctrl_oe_q, ctrl_oe_d, hold_grant_q, hold_grant_d, ack_q, ack_d, rvalid_q, rvalid_d;
  logic in_data;

  assign in_data = (state_d == ST_DATA || state_d == ST_WAIT);

  always_comb begin
    lad_o_d = lad_o_q;
    lad_oe_d = lad_oe_q;
    ale_n_d = lbus_pkg::STROBE_N_RST;
    ale_oe_d = ale_oe_q;
    ads_n_d = ads_n_q;
    wnr_d = wnr_q;
    dir_d = dir_q;
    den_n_d = den_n_q;
    ctrl_oe_d = ctrl_oe_q;
    hold_grant_d = hold_grant_q;
    ack_d = take;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    if (beat && !wr_q) begin
      rdata_d = lad_s;
      rvalid_d = 1'b1;
    end
    if (phase_q) begin
      ale_n_d = !(state_d == ST_ADDR);
      ads_n_d = !(state_d == ST_ADDR || (state_d == ST_DATA && beat));
      den_n_d = !in_data;
      ale_oe_d = (state_d != ST_HOLD);
      ctrl_oe_d = (state_d != ST_HOLD);
      hold_grant_d = (state_d == ST_HOLD);
      if (state_d == ST_ADDR) begin
        lad_o_d = {addr_d, len_d};
        lad_oe_d = 1'b1;
        wnr_d = wr_d;
        dir_d = wr_d && !intack_d;
      end else if (in_data && wr_d) begin
        lad_o_d = wf_pop ? wf_next : wf_data;
        lad_oe_d = 1'b1;
      end else begin
        lad_o_d = lbus_pkg::LAD_RST;
        lad_oe_d = 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      lad_o_q <= lbus_pkg::LAD_RST;
      lad_oe_q <= 1'b0;
      ale_n_q <= lbus_pkg::STROBE_N_RST;
      ale_oe_q <= 1'b1;
      ads_n_q <= lbus_pkg::STROBE_N_RST;
      wnr_q <= lbus_pkg::DIR_RST;
      dir_q <= lbus_pkg::DIR_RST;
      den_n_q <= lbus_pkg::STROBE_N_RST;
      ctrl_oe_q <= 1'b1;
      hold_grant_q <= 1'b0;
      ack_q <= 1'b0;
      rdata_q <= lbus_pkg::LAD_RST;
      rvalid_q <= 1'b0;
    end else begin
      lad_o_q <= lad_o_d;
      lad_oe_q <= lad_oe_d;
      ale_n_q <= ale_n_d;
      ale_oe_q <= ale_oe_d;
      ads_n_q <= ads_n_d;
      wnr_q <= wnr_d;
      dir_q <= dir_d;
      den_n_q <= den_n_d;
      ctrl_oe_q <= ctrl_oe_d;
      hold_grant_q <= hold_grant_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign PROC_CLK = phase_q;
  assign MUXED_ADDR_DATA_O = lad_o_q;
  assign MUXED_ADDR_DATA_OE = lad_oe_q;
  assign ADDR_LATCH_STROBE_N = ale_n_q;
  assign ADDR_LATCH_STROBE_OE = ale_oe_q;
  assign ADDR_DATA_STATUS_N = ads_n_q;
  assign WRITE_NOT_READ = wnr_q;
  assign TRANSCEIVER_DIRECTION = dir_q;
  assign DATA_ENABLE_N = den_n_q;
  assign CTRL_OE = ctrl_oe_q;
  assign HOLD_GRANT = hold_grant_q;
  assign REQ_ACK = ack_q;
  assign RDATA = rdata_q;
  assign RDATA_VALID = rvalid_q;
  // The lock line is only ever pulled low, and it is sensed back as well.
  assign BUS_LOCK_N_O = 1'b0;
  assign BUS_LOCK_N_OE = lock_q;

  // Checks.
  sequence s_ale_pulse;
    !ADDR_LATCH_STROBE_N ##1 ADDR_LATCH_STROBE_N;
  endsequence

  sequence s_ale_then_data;
    ADDR_LATCH_STROBE_N && DATA_ENABLE_N ##1 ADDR_LATCH_STROBE_N && !DATA_ENABLE_N;
  endsequence

  property p_clk_half;
    @(posedge SYS_CLK) disable iff (!RESETN)
      PROC_CLK |=> !PROC_CLK ##1 PROC_CLK;
  endproperty
  a_clk_half: assert property (p_clk_half) else $error("bus clock not half rate");

  property p_addr_fields;
    @(posedge SYS_CLK) disable iff (!RESETN)
      $fell(ADDR_LATCH_STROBE_N) |-> MUXED_ADDR_DATA_OE && MUXED_ADDR_DATA_O[1:0] == len_q
                                   && MUXED_ADDR_DATA_O[31:2] == addr_q;
  endproperty
  a_addr_fields: assert property (p_addr_fields) else $error("address state fields wrong");

  property p_float;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (DATA_ENABLE_N && ADDR_DATA_STATUS_N) |-> !MUXED_ADDR_DATA_OE;
  endproperty
  a_float: assert property (p_float) else $error("data lines driven while idle");

  property p_ale_order;
    @(posedge SYS_CLK) disable iff (!RESETN)
      $fell(ADDR_LATCH_STROBE_N) |-> s_ale_pulse ##0 s_ale_then_data;
  endproperty
  a_ale_order: assert property (p_ale_order) else $error("latch strobe not ended before data");

  property p_hold_float;
    @(posedge SYS_CLK) disable iff (!RESETN)
      HOLD_GRANT |-> !ADDR_LATCH_STROBE_OE && !MUXED_ADDR_DATA_OE && !BUS_LOCK_N_OE && !CTRL_OE;
  endproperty
  a_hold_float: assert property (p_hold_float) else $error("pins driven in hold");

  property p_dir_stable;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (!DATA_ENABLE_N && $past(!DATA_ENABLE_N)) |-> $stable(TRANSCEIVER_DIRECTION) && $stable(WRITE_NOT_READ);
  endproperty
  a_dir_stable: assert property (p_dir_stable) else $error("direction changed while enabled");

  property p_wait_quiet;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (state_q == ST_WAIT) |-> ADDR_DATA_STATUS_N && !DATA_ENABLE_N;
  endproperty
  a_wait_quiet: assert property (p_wait_quiet) else $error("status strobe in wait state");

  property p_status_in_addr;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (state_q == ST_ADDR && !phase_q) |-> !ADDR_DATA_STATUS_N ##2 ADDR_DATA_STATUS_N;
  endproperty
  a_status_in_addr: assert property (p_status_in_addr) else $error("status strobe wrong around address");

  property p_dir_follows_kind;
    @(posedge SYS_CLK) disable iff (!RESETN)
      !DATA_ENABLE_N |-> TRANSCEIVER_DIRECTION == (wr_q && !intack_q);
  endproperty
  a_dir_follows_kind: assert property (p_dir_follows_kind) else $error("direction does not match kind");

endmodule

// *** rtl/lbus_pkg.sv ***
package lbus_pkg;

  // Widths of the multiplexed bus and of its fields.
  localparam int WORD_W = 32;
  localparam int LEN_W = 2;
  localparam int ADDR_LSB = 2;
  localparam int LEN_LSB = 0;

  // Depth of the write-data buffer.
  localparam int WFIFO_DEPTH = 4;

  // The bus clock is the input clock divided by this ratio.
  localparam int CLK_DIV_RATIO = 2;

  // Number of synchronised pin bits: hold, ready, lock and the data lines.
  localparam int SYNC_W = WORD_W + 3;

  // Reset values of the pins.
  localparam logic [31:0] LAD_RST = 32'h0000_0000;
  localparam logic STROBE_N_RST = 1'b1;
  localparam logic DIR_RST = 1'b0;

  // Transfer lengths as carried in the low address bits.
  localparam logic [1:0] LEN_ONE = 2'h0;
  localparam logic [1:0] LEN_TWO = 2'h1;
  localparam logic [1:0] LEN_THREE = 2'h2;
  localparam logic [1:0] LEN_FOUR = 2'h3;

endpackage

// *** rtl/pin_sync.sv ***
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Pins and their synchronised copies.
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);

  if (W < 1) begin : g_bad_params
    $error("pin_sync needs W of at least 1");
  end

  generate
    for (genvar i = 0; i < W; i++) begin : g_bit
      logic first_q;
      logic second_q;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          first_q <= 1'b0;
          second_q <= 1'b0;
        end else begin
          first_q <= pin_in[i];
          second_q <= first_q;
        end
      end
      assign pin_out[i] = second_q;
    end
  endgenerate

endmodule

// *** rtl/word_fifo.sv ***
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [WIDTH-1:0] out_next,
  output logic [$clog2(DEPTH+1)-1:0] level
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_params
    $error("word_fifo needs DEPTH of at least 2 and WIDTH of at least 1");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] rd_q, rd_d, wr_q, wr_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic full_q, full_d, empty_q, empty_d;
  logic push, pop;

  assign push = in_valid && !full_q;
  assign pop = out_ready && !empty_q;

  always_comb begin
    rd_d = rd_q;
    wr_d = wr_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
    full_d = (cnt_d == CW'(DEPTH));
    empty_d = (cnt_d == '0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
      full_q <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      rd_q <= rd_d;
      wr_q <= wr_d;
      cnt_q <= cnt_d;
      full_q <= full_d;
      empty_q <= empty_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  assign in_ready = !full_q;
  assign out_valid = !empty_q;
  assign out_data = mem_q[rd_q];
  assign out_next = mem_q[(rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1];
  assign level = cnt_q;

endmodule

// *** bench/lbus_agent.sv ***
module lbus_agent (
  // Clock.
  input wire logic clk,
  // Bus pins seen by the agent.
  input wire logic [31:0] lad_o,
  input wire logic ale_n,
  input wire logic ads_n,
  input wire logic wnr,
  input wire logic den_n,
  // Clock cycles of delay before each ready, and the agent's answers.
  input wire logic [2:0] stall,
  output logic [31:0] lad_i,
  output logic ready_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [logic [29:0]];
  logic [32:0] aq [$];
  logic [31:0] wq [$];
  logic [29:0] a;
  logic [3:0] lanes_n;
  logic w;
  // Records one address state.
  task automatic take_addr;
    a = lad_o[31:2];
    w = wnr;
    aq.push_back({wnr, lad_o});
  endtask
  // Answers each data state, then lets the line drift once released.
  initial begin
    lad_i = 32'h0000_0000;
    ready_n = 1'b1;
    lanes_n = 4'hf;
    forever begin
      @(negedge clk);
      if (!ale_n) begin
        take_addr();
      end else if (!den_n) begin
        repeat (stall) @(negedge clk);
        if (w) begin
          mem[a] = lad_o;
          wq.push_back(lad_o);
        end else begin
          lad_i = mem.exists(a) ? mem[a] : ~{a, 2'b00};
          lanes_n = 4'h0;
        end
        // Ready stands for exactly one bus cycle, so the synchronised copy gives one beat.
        ready_n = 1'b0;
        repeat (2) @(negedge clk);
        ready_n = 1'b1;
        lanes_n = 4'hf;
        while (ads_n && !den_n) @(negedge clk);
        lad_i = ~lad_i;
        a = a + 30'h1;
        if (!ale_n) begin
          take_addr();
        end
      end
    end
  end
endmodule

// *** bench/tb_local_bus_master.sv ***
module tb_local_bus_master;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, resetn, req_valid, req_write, req_locked, req_intack, wdata_valid, foreign, hold_req, p;
  logic req_ack, wdata_ready, rdata_valid, proc_clk, lad_oe, ale_n, ale_oe, ads_n, wnr, dir, den_n;
  logic ctrl_oe, ready_n, lock_n_o, lock_oe, lock_in, ale_pin, hold_grant;
  logic [29:0] req_word_addr;
  logic [1:0] req_len;
  logic [2:0] stall;
  logic [31:0] wdata, lad_i, lad_o, lad_in, rdata;
  logic [31:0] em [logic [29:0]];
  logic [32:0] eaq [$];
  logic [31:0] ewq [$], erq [$], grq [$];
  int mismatches, checks_done, kind_q, seed, t;

  assign lad_in = lad_oe ? lad_o : lad_i;
  assign lock_in = (lock_oe ? lock_n_o : 1'b1) & ~foreign;
  assign ale_pin = ale_oe ? ale_n : 1'b1;
  always #2 sys_clk = ~sys_clk;

  local_bus_master i_dut (
    .SYS_CLK(sys_clk), .RESETN(resetn), .REQ_VALID(req_valid), .REQ_ACK(req_ack), .REQ_WRITE(req_write),
    .REQ_LOCKED(req_locked), .REQ_INTACK(req_intack), .REQ_WORD_ADDR(req_word_addr), .REQ_LEN(req_len),
    .WDATA_VALID(wdata_valid), .WDATA_READY(wdata_ready), .WDATA(wdata), .RDATA_VALID(rdata_valid),
    .RDATA(rdata), .PROC_CLK(proc_clk), .MUXED_ADDR_DATA_I(lad_in), .MUXED_ADDR_DATA_O(lad_o),
    .MUXED_ADDR_DATA_OE(lad_oe), .ADDR_LATCH_STROBE_N(ale_n), .ADDR_LATCH_STROBE_OE(ale_oe),
    .ADDR_DATA_STATUS_N(ads_n), .WRITE_NOT_READ(wnr), .TRANSCEIVER_DIRECTION(dir), .DATA_ENABLE_N(den_n),
    .CTRL_OE(ctrl_oe), .READY_N(ready_n), .BUS_LOCK_N_I(lock_in), .BUS_LOCK_N_O(lock_n_o),
    .BUS_LOCK_N_OE(lock_oe), .HOLD_REQ(hold_req), .HOLD_GRANT(hold_grant));
  lbus_agent i_agent (.clk(sys_clk), .lad_o(lad_o), .ale_n(ale_pin), .ads_n(ctrl_oe ? ads_n : 1'b1), .wnr(wnr),
    .den_n(ctrl_oe ? den_n : 1'b1), .stall(stall), .lad_i(lad_i), .ready_n(ready_n));

  task automatic cmp_w(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_b(input logic got, input logic exp);
    cmp_w({32'h0, got}, {32'h0, exp});
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Runs one transaction and compares address, read and write words with the model.
  task automatic xfer(input int kind, input logic [29:0] ad, input logic [1:0] ln);
    logic [29:0] wa;
    logic [31:0] d;
    int i;
    stall = 3'($random(seed));
    kind_q = kind;
    wdata_valid = kind == 1;
    for (i = 0; i <= int'(ln); i++) begin
      wa = ad + 30'(i);
      if (kind == 1) begin
        d = $random(seed);
        em[wa] = d;
        ewq.push_back(d);
        wdata = d;
        while (wdata_ready !== 1'b1) @(negedge sys_clk);
        @(negedge sys_clk);
      end else begin
        erq.push_back(em.exists(wa) ? em[wa] : ~{wa, 2'b00});
      end
    end
    wdata_valid = 1'b0;
    if (kind == 1 && ln == 2'h3) cmp_b(wdata_ready, 1'b0);
    eaq.push_back({kind == 1, ad, ln});
    {req_write, req_locked, req_intack} = {kind == 1, kind == 2, kind == 3};
    req_word_addr = ad;
    req_len = ln;
    req_valid = 1'b1;
    for (t = 0; req_ack !== 1'b1 && t < 300; t++) @(negedge sys_clk);
    cmp_b(req_ack, 1'b1);
    req_valid = 1'b0;
    for (t = 0; (grq.size() < erq.size() || i_agent.wq.size() < ewq.size() || den_n !== 1'b1) && t < 400; t++) begin
      @(negedge sys_clk);
    end
    cmp_b(lad_oe, 1'b0);
    cmp_w(33'(i_agent.aq.size()), 33'(eaq.size()));
    while (eaq.size() > 0 && i_agent.aq.size() > 0) cmp_w(i_agent.aq.pop_front(), eaq.pop_front());
    cmp_w(33'(grq.size() + i_agent.wq.size()), 33'(erq.size() + ewq.size()));
    while (erq.size() > 0 && grq.size() > 0) cmp_w(33'(grq.pop_front()), 33'(erq.pop_front()));
    while (ewq.size() > 0 && i_agent.wq.size() > 0) cmp_w(33'(i_agent.wq.pop_front()), 33'(ewq.pop_front()));
  endtask

  // Collects read words and watches the control pins through every data state.
  always @(negedge sys_clk) begin
    if (rdata_valid === 1'b1) grq.push_back(rdata);
    if (den_n === 1'b0) begin
      cmp_b(dir, kind_q == 1);
      cmp_b(wnr, kind_q == 1);
      if (kind_q >= 2) cmp_b(lock_oe, 1'b1);
    end
  end

  // Cuts a hang short long after the expected few hundred cycles.
  initial begin
    #200000;
    mismatches++;
    end_of_test();
  end

  initial begin
    {sys_clk, resetn, req_valid, req_write, req_locked, req_intack, wdata_valid, foreign, hold_req} = 9'h000;
    req_word_addr = 30'h0;
    req_len = 2'h0;
    wdata = 32'h0000_0000;
    stall = 3'h0;
    seed = 32'h4fdad268;
    repeat (8) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (2) @(negedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      p = proc_clk;
      @(negedge sys_clk);
      cmp_b(proc_clk, ~p);
    end
    for (int i = 0; i < 12; i++) begin
      xfer(i % 3 == 2 ? 3 : i % 3, 30'($random(seed)) & 30'h000f, 2'(i / 3));
    end
    cmp_b(lock_oe, 1'b0);
    foreign = 1'b1;
    repeat (4) @(negedge sys_clk);
    fork
      xfer(2, 30'h0004, 2'h0);
      begin
        repeat (20) @(negedge sys_clk);
        cmp_w(33'(i_agent.aq.size()), 33'h0);
        foreign = 1'b0;
      end
    join
    cmp_b(lock_oe, 1'b1);
    xfer(1, 30'h0004, 2'h0);
    cmp_b(lock_oe, 1'b0);
    hold_req = 1'b1;
    for (t = 0; hold_grant !== 1'b1 && t < 100; t++) @(negedge sys_clk);
    cmp_w({28'h0, hold_grant, lad_oe, ale_oe, ctrl_oe, lock_oe}, 33'h0010);
    hold_req = 1'b0;
    for (t = 0; hold_grant !== 1'b0 && t < 100; t++) @(negedge sys_clk);
    cmp_b(hold_grant, 1'b0);
    xfer(0, 30'h0004, 2'h3);
    end_of_test();
  end
endmodule
